// *** shared/bk3_pkg.sv ***
// package for the buck3 control register block
package bk3_pkg;
   // register offsets (printed offsets are not multiples of four: kept as indices)
   localparam logic [15:0] BK3_CTRL1_IDX   = 16'h4060;
   localparam logic [15:0] BK3_CTRL2_IDX   = 16'h4061;
   localparam logic [15:0] BK3_ONCFG_IDX   = 16'h4062;
   localparam logic [15:0] BK3_SLPCFG_IDX  = 16'h4063;
   localparam logic [15:0] BK3_IRQ_STS_IDX = 16'h4070;
   localparam logic [15:0] BK3_IRQ_MSK_IDX = 16'h4071;
   localparam logic [15:0] BK3_KEY_IDX     = 16'h4072;
   localparam logic [15:0] BK3_STATUS_IDX  = 16'h4073;
   // field positions, control one
   localparam int BK3_CLKINV_BIT = 12;
   localparam int BK3_FLOAT_BIT  = 7;
   localparam int BK3_SS_LO      = 4;
   localparam int BK3_HCL_LO     = 2;
   localparam int BK3_CAP_LO     = 0;
   // field positions, control two
   localparam int BK3_UVA_LO     = 14;
   localparam int BK3_HSRC_LO    = 11;
   localparam int BK3_HVSEL_BIT  = 10;
   localparam int BK3_HMODE_LO   = 8;
   localparam int BK3_OVP_BIT    = 7;
   // field positions, on and sleep config
   localparam int BK3_MODE_LO    = 8;
   // reset values and write masks
   localparam logic [15:0] BK3_CTRL1_RST  = 16'h0014;
   localparam logic [15:0] BK3_CTRL2_RST  = 16'h0300;
   localparam logic [15:0] BK3_ONCFG_RST  = 16'h0100;
   localparam logic [15:0] BK3_SLPCFG_RST = 16'h0300;
   localparam logic [15:0] BK3_CTRL1_MASK = 16'h10BF;
   localparam logic [15:0] BK3_CTRL2_MASK = 16'hDF80;
   localparam logic [15:0] BK3_CFG_MASK   = 16'h037F;
   // security key value, arbitrary
   localparam logic [15:0] BK3_KEY_VALUE  = 16'h9A5C;
   // voltage code saturation
   localparam logic [6:0]  BK3_VCODE_MAX  = 7'h66;
   // interrupt status bits
   localparam int BK3_IRQ_UV = 0;
   localparam int BK3_IRQ_OV = 1;
   // timing
   localparam longint BK3_CLK_HZ     = 40000000;
   localparam longint BK3_SS1_NS     = 512000;
   localparam longint BK3_SS2_NS     = 4096000;
   localparam longint BK3_SS3_NS     = 32768000;
   localparam longint BK3_TICK_NS    = 512000;
   localparam int     BK3_TICK_CYC   = int'((BK3_TICK_NS * BK3_CLK_HZ + 64'd999999999) / 64'd1000000000);
   localparam int     BK3_SS_STEPS   = 3;
   localparam logic [6:0] BK3_SS1_TICKS = 7'(BK3_SS1_NS / BK3_TICK_NS);
   localparam logic [6:0] BK3_SS2_TICKS = 7'(BK3_SS2_NS / BK3_TICK_NS);
   localparam logic [6:0] BK3_SS3_TICKS = 7'(BK3_SS3_NS / BK3_TICK_NS);

   // operating modes
   localparam logic [1:0] BK3_MODE_FCCM = 2'h0;
   localparam logic [1:0] BK3_MODE_AUTO = 2'h1;
   localparam logic [1:0] BK3_MODE_LDO  = 2'h2;
   localparam logic [1:0] BK3_MODE_HYST = 2'h3;
   // undervoltage actions
   localparam logic [1:0] BK3_UVA_IGNORE = 2'h0;
   localparam logic [1:0] BK3_UVA_OFF    = 2'h1;
   localparam logic [1:0] BK3_UVA_RESET  = 2'h2;

   typedef struct packed {
      logic       enable;
      logic       clock_invert;
      logic       float_when_off;
      logic       discharge;
      logic [1:0] op_mode;
      logic [6:0] voltage_code;
      logic [1:0] current_step;
      logic [1:0] hyst_current_limit;
      logic [1:0] output_cap_range;
      logic       overvolt_protect;
   } bk3_drive_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } bk3_bus_s;
endpackage

// *** src/bk3_control_regs.sv ***
// buck3 converter control registers and hardware-control logic
// Function
// RL1: bit 12 inverts converter switching clock phase
// RL2: float bit: discharge or float when disabled
// RL3: soft-start field sets each of three steps
// RL4: bits 3:2 set hysteretic current limit
// RL5: current-limit writes need unlocked security key
// RL6: undervoltage action: ignore, off, system reset
// RL7: every undervoltage raises an interrupt; code sets status on each rise, but irq_q only with mask bit 0 set
// RL8: source selects hardware-control input one/two/either
// RL9: hardware control picks ON or SLEEP voltage
// RL10: hardware-control mode field, 01 disables converter
// RL11: output capacitor range field at bits 1:0
// RL12: ON voltage code saturates at top code
// RL13: input asserted applies hardware settings, else ON
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module bk3_control_regs
   import bk3_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // register port
   input  wire logic [15:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [15:0]      reg_rdata_q,
   // hardware-control inputs and converter monitors
   input  wire logic        hwctl_in1,
   input  wire logic        hwctl_in2,
   input  wire logic        buck3_undervolt,
   input  wire logic        buck3_overvolt,
   input  wire logic        buck3_enable_req,
   // converter drive
   output bk3_drive_s       drive_q,
   output logic             system_reset_req_q,
   output logic             irq_q
);
   logic [15:0] ctrl1_q;
   logic [15:0] ctrl2_q;
   logic [15:0] oncfg_q;
   logic [15:0] slpcfg_q;
   logic        unlocked_q;
   logic        uv_off_q;
   logic        uv_prev_q;
   logic        ov_prev_q;
   logic        uv_rise;
   logic        ov_rise;
   logic        hw_active;
   logic        conv_on;
   logic [1:0]  sel_mode;
   logic [6:0]  sel_code;
   logic [1:0]  ss_step;
   logic        ss_done;
   logic [1:0]  irq_sts;
   logic [1:0]  irq_msk;
   bk3_drive_s  drive_d;
   logic [15:0] rdata_d;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
      return a == idx;
   endfunction

   function automatic logic [6:0] sat_code(input logic [6:0] c);
      return (c > BK3_VCODE_MAX) ? BK3_VCODE_MAX : c; // [RL12]
   endfunction

   // security key: writing the key value unlocks, any other value locks
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         unlocked_q <= 1'b0;
      end else if (reg_wr && hit(reg_addr, BK3_KEY_IDX)) begin
         unlocked_q <= (reg_wdata == BK3_KEY_VALUE);
      end
   end

   // control one
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ctrl1_q <= BK3_CTRL1_RST;
      end else if (reg_wr && hit(reg_addr, BK3_CTRL1_IDX)) begin
         ctrl1_q <= reg_wdata & BK3_CTRL1_MASK;
         if (!unlocked_q) begin
            ctrl1_q[BK3_HCL_LO +: 2] <= ctrl1_q[BK3_HCL_LO +: 2]; // [RL5]
         end
      end
   end

   // control two
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ctrl2_q <= BK3_CTRL2_RST;
      end else if (reg_wr && hit(reg_addr, BK3_CTRL2_IDX)) begin
         ctrl2_q <= reg_wdata & BK3_CTRL2_MASK;
      end
   end

   // ON and SLEEP voltage and mode
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         oncfg_q  <= BK3_ONCFG_RST;
         slpcfg_q <= BK3_SLPCFG_RST;
      end else if (reg_wr && hit(reg_addr, BK3_ONCFG_IDX)) begin
         oncfg_q <= reg_wdata & BK3_CFG_MASK;
      end else if (reg_wr && hit(reg_addr, BK3_SLPCFG_IDX)) begin
         slpcfg_q <= reg_wdata & BK3_CFG_MASK;
      end
   end

   // event edges
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         uv_prev_q <= 1'b0;
         ov_prev_q <= 1'b0;
      end else begin
         uv_prev_q <= buck3_undervolt;
         ov_prev_q <= buck3_overvolt && ctrl2_q[BK3_OVP_BIT];
      end
   end
   assign uv_rise = buck3_undervolt && !uv_prev_q;
   assign ov_rise = buck3_overvolt && ctrl2_q[BK3_OVP_BIT] && !ov_prev_q;

   // undervoltage response
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         uv_off_q           <= 1'b0;
         system_reset_req_q <= 1'b0;
      end else begin
         system_reset_req_q <= uv_rise && (ctrl2_q[BK3_UVA_LO +: 2] == BK3_UVA_RESET); // [RL6]
         if (!buck3_enable_req) begin
            uv_off_q <= 1'b0;
         end else if (uv_rise && ctrl2_q[BK3_UVA_LO +: 2] == BK3_UVA_OFF) begin
            uv_off_q <= 1'b1; // [RL6]
         end
      end
   end

   // hardware-control source decode
   always_comb begin
      case (ctrl2_q[BK3_HSRC_LO +: 2]) // [RL8]
         2'h1:    hw_active = hwctl_in1;
         2'h2:    hw_active = hwctl_in2;
         2'h3:    hw_active = hwctl_in1 | hwctl_in2;
         default: hw_active = 1'b0;
      endcase
   end

   // select applied voltage and mode
   always_comb begin
      if (hw_active) begin // [RL13]
         sel_code = ctrl2_q[BK3_HVSEL_BIT] ? slpcfg_q[6:0] : oncfg_q[6:0]; // [RL9]
         sel_mode = ctrl2_q[BK3_HMODE_LO +: 2]; // [RL10]
         conv_on  = buck3_enable_req && (ctrl2_q[BK3_HMODE_LO +: 2] != BK3_MODE_AUTO); // [RL10]
      end else begin
         sel_code = oncfg_q[6:0];
         sel_mode = oncfg_q[BK3_MODE_LO +: 2];
         conv_on  = buck3_enable_req;
      end
      conv_on = conv_on && !uv_off_q;
   end

   bk3_softstart u_softstart (
      .sys_clk              (sys_clk),
      .reset                (reset),
      .run                  (conv_on),
      .buck3_softstart_step (ctrl1_q[BK3_SS_LO +: 2]),
      .step_q               (ss_step),
      .done_q               (ss_done)
   );

   // drive bundle
   always_comb begin
      drive_d                    = '0;
      drive_d.enable             = conv_on;
      drive_d.clock_invert       = ctrl1_q[BK3_CLKINV_BIT]; // [RL1]
      drive_d.float_when_off     = !conv_on && ctrl1_q[BK3_FLOAT_BIT]; // [RL2]
      drive_d.discharge          = !conv_on && !ctrl1_q[BK3_FLOAT_BIT]; // [RL2]
      drive_d.op_mode            = sel_mode;
      drive_d.voltage_code       = sat_code(sel_code); // [RL12]
      drive_d.current_step       = ss_step; // [RL3]
      drive_d.hyst_current_limit = ctrl1_q[BK3_HCL_LO +: 2]; // [RL4]
      drive_d.output_cap_range   = ctrl1_q[BK3_CAP_LO +: 2]; // [RL11]
      drive_d.overvolt_protect   = ctrl2_q[BK3_OVP_BIT];
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         drive_q <= '0;
      end else begin
         drive_q <= drive_d;
      end
   end

   // interrupts: undervoltage status always set, independent of action; irq_q only when mask bit set
   bk3_irq u_irq (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .event_set ({ov_rise, uv_rise}), // [RL7]
      .sts_wr    (reg_wr && hit(reg_addr, BK3_IRQ_STS_IDX)),
      .msk_wr    (reg_wr && hit(reg_addr, BK3_IRQ_MSK_IDX)),
      .wdata     (reg_wdata[1:0]),
      .sts_q     (irq_sts),
      .msk_q     (irq_msk),
      .irq_q     (irq_q)
   );

   // read mux
   always_comb begin
      case (reg_addr)
         BK3_CTRL1_IDX:   rdata_d = ctrl1_q;
         BK3_CTRL2_IDX:   rdata_d = ctrl2_q;
         BK3_ONCFG_IDX:   rdata_d = oncfg_q;
         BK3_SLPCFG_IDX:  rdata_d = slpcfg_q;
         BK3_IRQ_STS_IDX: rdata_d = {14'h0000, irq_sts};
         BK3_IRQ_MSK_IDX: rdata_d = {14'h0000, irq_msk};
         BK3_KEY_IDX:     rdata_d = {15'h0000, unlocked_q};
         BK3_STATUS_IDX:  rdata_d = {11'h000, uv_off_q, hw_active, ss_done, ss_step};
         default:         rdata_d = 16'h0000;
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         reg_rdata_q <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata_q <= rdata_d;
      end else begin
         reg_rdata_q <= 16'h0000;
      end
   end
endmodule // bk3_control_regs

// *** src/bk3_irq.sv ***
// sticky interrupt status with mask for buck3
`timescale 1ns/1ps
module bk3_irq
   import bk3_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset,
   // events and software access
   input  wire logic [1:0] event_set,
   input  wire logic       sts_wr,
   input  wire logic       msk_wr,
   input  wire logic [1:0] wdata,
   // state
   output logic [1:0]      sts_q,
   output logic [1:0]      msk_q,
   output logic            irq_q
);
   // set wins over write-one-to-clear
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sts_q <= 2'h0;
      end else begin
         sts_q <= (sts_q & ~(sts_wr ? wdata : 2'h0)) | event_set;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         msk_q <= 2'h0;
      end else if (msk_wr) begin
         msk_q <= wdata;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(((sts_q & ~(sts_wr ? wdata : 2'h0)) | event_set) & msk_q);
      end
   end
endmodule // bk3_irq

// *** src/bk3_softstart.sv ***
// soft-start step sequencer for the buck3 converter
`timescale 1ns/1ps
module bk3_softstart
   import bk3_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset,
   // control
   input  wire logic       run,
   input  wire logic [1:0] buck3_softstart_step,
   // status
   output logic [1:0]      step_q,
   output logic            done_q
);
   typedef enum logic [2:0] {
      BK3_SS_IDLE = 3'b001,
      BK3_SS_STEP = 3'b010,
      BK3_SS_DONE = 3'b100
   } bk3_ss_e;

   bk3_ss_e    state_q;
   logic [6:0] ticks_q;
   logic [6:0] limit;
   logic [15:0] div_q;
   logic        tick;

   always_comb begin
      case (buck3_softstart_step)
         2'h1:    limit = BK3_SS1_TICKS;
         2'h2:    limit = BK3_SS2_TICKS;
         default: limit = BK3_SS3_TICKS;
      endcase
   end

   // 512us tick divider
   assign tick = (div_q == 16'(BK3_TICK_CYC - 1));
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         div_q <= 16'h0000;
      end else if (!run || tick) begin
         div_q <= 16'h0000;
      end else begin
         div_q <= div_q + 16'h0001;
      end
   end

   // three intermediate current steps [RL3]
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_q <= BK3_SS_IDLE;
         ticks_q <= 7'h00;
         step_q  <= 2'h0;
         done_q  <= 1'b0;
      end else if (!run) begin
         state_q <= BK3_SS_IDLE;
         ticks_q <= 7'h00;
         step_q  <= 2'h0;
         done_q  <= 1'b0;
      end else begin
         case (state_q)
            BK3_SS_IDLE: begin
               if (buck3_softstart_step == 2'h0) begin
                  state_q <= BK3_SS_DONE;
                  step_q  <= 2'(BK3_SS_STEPS);
                  done_q  <= 1'b1;
               end else begin
                  state_q <= BK3_SS_STEP;
                  step_q  <= 2'h1;
               end
            end
            BK3_SS_STEP: begin
               if (tick) begin
                  if (ticks_q + 7'h01 >= limit) begin
                     ticks_q <= 7'h00;
                     if (step_q == 2'(BK3_SS_STEPS)) begin
                        state_q <= BK3_SS_DONE;
                        done_q  <= 1'b1;
                     end else begin
                        step_q <= step_q + 2'h1;
                     end
                  end else begin
                     ticks_q <= ticks_q + 7'h01;
                  end
               end
            end
            BK3_SS_DONE: done_q <= 1'b1;
            default:     state_q <= BK3_SS_IDLE;
         endcase
      end
   end
endmodule // bk3_softstart

// *** tb/bk3_control_regs_sva.sv ***
// assertions for the buck3 control register block
`timescale 1ns/1ps
module bk3_control_regs_sva
   import bk3_pkg::*;
(
   // clock, reset and register port
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   // pins and converter drive
   input wire logic        hwctl_in1,
   input wire logic        hwctl_in2,
   input wire logic        buck3_undervolt,
   input wire bk3_drive_s  drive_q,
   input wire logic        system_reset_req_q,
   input wire logic        irq_q
);
   logic [15:0] c1_q;
   logic [15:0] c2_q;
   logic        key_q;
   logic        msk_q;
   logic        hw_act;
   assign hw_act = (c2_q[11] & hwctl_in1) | (c2_q[12] & hwctl_in2);
   // shadow of control one, limit field kept while locked
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         c1_q <= BK3_CTRL1_RST;
      end else if (reg_wr && reg_addr == BK3_CTRL1_IDX) begin
         c1_q <= reg_wdata & BK3_CTRL1_MASK & (key_q ? 16'hFFFF : 16'hFFF3) | c1_q & (key_q ? 16'h0000 : 16'h000C);
      end
   end
   // shadow of control two
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         c2_q <= BK3_CTRL2_RST;
      end else if (reg_wr && reg_addr == BK3_CTRL2_IDX) begin
         c2_q <= reg_wdata & BK3_CTRL2_MASK;
      end
   end
   // key and mask shadows
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         key_q <= 1'b0;
         msk_q <= 1'b0;
      end else if (reg_wr && reg_addr == BK3_KEY_IDX) begin
         key_q <= (reg_wdata == BK3_KEY_VALUE);
      end else if (reg_wr && reg_addr == BK3_IRQ_MSK_IDX) begin
         msk_q <= reg_wdata[0];
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   sequence s_uv(logic [1:0] act);
      $rose(buck3_undervolt) && c2_q[15:14] == act;
   endsequence
   a_clock_invert: assert property (!$past(reset) |-> drive_q.clock_invert == $past(c1_q[12]))
      else $error("clock invert differs from control one");
   a_float_copy: assert property (!$past(reset) |->
      drive_q.float_when_off == (!drive_q.enable && $past(c1_q[7])))
      else $error("float bit differs from control one");
   a_disch_off: assert property (!$past(reset) && !drive_q.enable |-> drive_q.discharge != drive_q.float_when_off)
      else $error("discharge wrong while disabled");
   a_hyst_limit: assert property (!$past(reset) |-> drive_q.hyst_current_limit == $past(c1_q[3:2]))
      else $error("current limit differs from protected field");
   a_cap_range: assert property (!$past(reset) |-> drive_q.output_cap_range == $past(c1_q[1:0]))
      else $error("capacitor range differs from control one");
   a_ss_immediate: assert property ($rose(drive_q.enable) && c1_q[5:4] == 2'h0 |-> ##[0:2] drive_q.current_step == 2'h3)
      else $error("immediate start did not reach last step");
   a_uv_irq: assert property ($rose(buck3_undervolt) && msk_q |-> ##[1:2] irq_q)
      else $error("undervoltage raised no interrupt");
   a_uv_off: assert property (s_uv(BK3_UVA_OFF) |-> ##[1:3] !drive_q.enable)
      else $error("undervoltage did not shut converter");
   a_uv_reset: assert property (s_uv(BK3_UVA_RESET) |-> ##[1:2] system_reset_req_q)
      else $error("undervoltage did not request reset");
   a_reset_cause: assert property (system_reset_req_q |-> c2_q[15:14] == BK3_UVA_RESET ##1 !system_reset_req_q)
      else $error("reset request without reset action or too long");
   a_hw_disable: assert property (hw_act && c2_q[9:8] == 2'h1 |=> !drive_q.enable)
      else $error("hardware disable mode left converter on");
   a_hw_mode: assert property (hw_act && c2_q[9:8] != 2'h1 |=> drive_q.op_mode == $past(c2_q[9:8]))
      else $error("hardware mode not applied");
   a_vcode_sat: assert property (drive_q.voltage_code <= BK3_VCODE_MAX)
      else $error("voltage code above top code");
endmodule // bk3_control_regs_sva

bind bk3_control_regs bk3_control_regs_sva chk_u (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .hwctl_in1,
   .hwctl_in2, .buck3_undervolt, .drive_q, .system_reset_req_q, .irq_q);

// *** tb/tb_bk3_control_regs.sv ***
// self-checking testbench for the buck3 control register block
`timescale 1ns/1ps
module tb_bk3_control_regs
   import bk3_pkg::*;
;
   localparam int SS_CYC = 512 * 40;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        hwctl_in1 = 1'b0;
   logic        hwctl_in2 = 1'b0;
   logic        buck3_undervolt = 1'b0;
   logic        buck3_overvolt = 1'b0;
   logic        buck3_enable_req = 1'b0;
   logic [15:0] reg_rdata_q;
   bk3_drive_s  drive_q;
   logic        system_reset_req_q;
   logic        irq_q;
   int          err_count = 0;
   int          compares = 0;
   int          cyc = 0;
   always #12.5 sys_clk = ~sys_clk;
   bk3_control_regs dut_u (
      .sys_clk           (sys_clk),
      .reset             (reset),
      .reg_addr          (reg_addr),
      .reg_wdata         (reg_wdata),
      .reg_wr            (reg_wr),
      .reg_rd            (reg_rd),
      .reg_rdata_q       (reg_rdata_q),
      .hwctl_in1         (hwctl_in1),
      .hwctl_in2         (hwctl_in2),
      .buck3_undervolt   (buck3_undervolt),
      .buck3_overvolt    (buck3_overvolt),
      .buck3_enable_req  (buck3_enable_req),
      .drive_q           (drive_q),
      .system_reset_req_q(system_reset_req_q),
      .irq_q             (irq_q)
   );
   task automatic tally_and_finish();
      $display("err_count=%0d compares=%0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata_q;
   endtask
   task automatic wait_step(input logic [1:0] s, output int n);
      n = 0;
      while (drive_q.current_step !== s && n < 40000) begin
         settle(1);
         n++;
      end
   endtask
   // reset values, masking, key protection
   task automatic t_regs();
      logic [15:0] d;
      rd(BK3_CTRL1_IDX, d);
      chk(d, 16'h0014);
      rd(BK3_CTRL2_IDX, d);
      chk(d, 16'h0300);
      wr(16'h4080, 16'hFFFF);
      rd(16'h4080, d);
      chk(d, 16'h0000);
      wr(BK3_CTRL1_IDX, 16'hFFFF);
      rd(BK3_CTRL1_IDX, d);
      chk(d, 16'h10B7);
      settle(1);
      chk({10'h0, drive_q.clock_invert, drive_q.float_when_off, drive_q.hyst_current_limit, drive_q.output_cap_range},
          16'h0037);
      wr(BK3_KEY_IDX, BK3_KEY_VALUE);
      wr(BK3_CTRL1_IDX, 16'h0008);
      rd(BK3_CTRL1_IDX, d);
      chk(d, 16'h0008);
      chk({14'h0, drive_q.hyst_current_limit}, 16'h0002);
      wr(BK3_KEY_IDX, 16'h0000);
      wr(BK3_CTRL1_IDX, 16'h0014);
      rd(BK3_CTRL1_IDX, d);
      chk(d, 16'h0018);
   endtask
   // soft-start step timing and output discharge
   task automatic t_softstart();
      int n;
      @(posedge sys_clk);
      buck3_enable_req <= 1'b1;
      wait_step(2'h1, n);
      wait_step(2'h2, n);
      chk(16'(n >= SS_CYC - 2 && n <= SS_CYC + 2), 16'h0001);
      wait_step(2'h3, n);
      chk(16'(n >= SS_CYC - 2 && n <= SS_CYC + 2), 16'h0001);
      @(posedge sys_clk);
      buck3_enable_req <= 1'b0;
      settle(3);
      chk({14'h0, drive_q.enable, drive_q.discharge}, 16'h0001);
      wr(BK3_CTRL1_IDX, 16'h0080);
      settle(3);
      chk({14'h0, drive_q.enable, drive_q.discharge}, 16'h0000);
      wr(BK3_CTRL1_IDX, 16'h0000);
      @(posedge sys_clk);
      buck3_enable_req <= 1'b1;
      settle(3);
      chk({14'h0, drive_q.current_step}, 16'h0003);
      wr(BK3_CTRL1_IDX, 16'h0020);
      @(posedge sys_clk);
      buck3_enable_req <= 1'b0;
      @(posedge sys_clk);
      buck3_enable_req <= 1'b1;
      wait_step(2'h1, n);
      settle(SS_CYC + 4);
      chk({14'h0, drive_q.current_step}, 16'h0001);
      wr(BK3_CTRL1_IDX, 16'h0000);
   endtask
   // every source, input pair and mode under hardware control
   task automatic t_hwctl();
      logic        act;
      logic [15:0] exp;
      wr(BK3_ONCFG_IDX, 16'h017F);
      wr(BK3_SLPCFG_IDX, 16'h0210);
      for (int m = 0; m < 4; m++) begin
         for (int k = 0; k < 16; k++) begin
            wr(BK3_CTRL2_IDX, {3'h0, 2'(k >> 2), m == 2, 2'(m), 8'h00});
            @(posedge sys_clk);
            hwctl_in1 <= k[0];
            hwctl_in2 <= k[1];
            settle(3);
            act = (k[2] & k[0]) | (k[3] & k[1]);
            exp = {!(act && m == 1), act ? 2'(m) : 2'h1, 6'h0, (act && m == 1) ? 7'h00 : (act && m == 2) ? 7'h10 : 7'h66};
            chk({drive_q.enable, drive_q.op_mode, 6'h0, drive_q.enable ? drive_q.voltage_code : 7'h00}, exp);
         end
      end
      @(posedge sys_clk);
      hwctl_in1 <= 1'b0;
      hwctl_in2 <= 1'b0;
   endtask
   // undervoltage actions, interrupt, mask and clear
   task automatic t_undervolt();
      logic [15:0] d;
      logic        rs;
      for (int a = 0; a < 5; a++) begin
         wr(BK3_CTRL2_IDX, 16'(a % 4) << 14);
         wr(BK3_IRQ_MSK_IDX, 16'(a < 4));
         @(posedge sys_clk);
         buck3_undervolt <= 1'b1;
         rs = 1'b0;
         repeat (4) begin
            settle(1);
            rs = rs | system_reset_req_q;
         end
         chk({14'h0, irq_q, drive_q.enable}, {14'h0, a < 4, a % 4 != 1});
         chk({15'h0, rs}, {15'h0, a == 2});
         rd(BK3_IRQ_STS_IDX, d);
         chk(d & 16'h0001, 16'h0001);
         @(posedge sys_clk);
         buck3_undervolt <= 1'b0;
         buck3_enable_req <= 1'b0;
         wr(BK3_IRQ_STS_IDX, 16'h0001);
         @(posedge sys_clk);
         buck3_enable_req <= 1'b1;
         settle(3);
         chk({15'h0, irq_q}, 16'h0000);
      end
   endtask
   // overvoltage interrupt gated by protect enable
   task automatic t_overvolt();
      logic [15:0] d;
      wr(BK3_IRQ_MSK_IDX, 16'h0002);
      @(posedge sys_clk);
      buck3_overvolt <= 1'b1;
      settle(3);
      rd(BK3_IRQ_STS_IDX, d);
      chk(d, 16'h0000);
      @(posedge sys_clk);
      buck3_overvolt <= 1'b0;
      wr(BK3_CTRL2_IDX, 16'h0080);
      @(posedge sys_clk);
      buck3_overvolt <= 1'b1;
      settle(3);
      chk({14'h0, irq_q, drive_q.overvolt_protect}, 16'h0003);
      rd(BK3_IRQ_STS_IDX, d);
      chk(d, 16'h0002);
      @(posedge sys_clk);
      buck3_overvolt <= 1'b0;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 100000) begin
         err_count++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      t_regs();
      t_softstart();
      t_hwctl();
      t_undervolt();
      t_overvolt();
      tally_and_finish();
   end
endmodule // tb_bk3_control_regs
